// ===== design/pcr_pkg.sv
// constants, field positions and carriers for the capability register bank
// assumes a 32-bit axi4-lite slave with byte addresses
package pcr_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [11:0] OFS_HEADER   = 12'h080;  // capability_header
  localparam logic [11:0] OFS_DEV_CAP  = 12'h084;  // device_capabilities
  localparam logic [11:0] OFS_DEV_CS   = 12'h088;  // device_control_status
  localparam logic [11:0] OFS_LINK_CAP = 12'h08c;  // link_capabilities
  localparam logic [11:0] OFS_CAP_LAST = 12'h0b0;  // last word of the structure
  localparam logic [11:0] OFS_IRQ_STAT = 12'h0c0;  // event status, write one to clear
  localparam logic [11:0] OFS_IRQ_MASK = 12'h0c4;  // event enable mask

  // ==========================================================================
  // header fields
  localparam logic [7:0] HDR_CAP_ID   = 8'h01;  // capability id
  localparam logic [7:0] HDR_NEXT_PTR = 8'h80;  // next capability pointer
  localparam logic [2:0] HDR_VERSION  = 3'h3;   // structure version

  // ==========================================================================
  // device control / status and capability bit positions
  localparam int DC_ERR_EN_LSB  = 0;   // four error reporting enables
  localparam int DC_RELAX       = 4;   // relaxed ordering
  localparam int DC_MPS_LSB     = 5;   // max payload size
  localparam int DC_EXT_TAG     = 8;   // extended tag enable
  localparam int DC_NOSNOOP     = 11;  // no-snoop enable
  localparam int DC_MRRS_LSB    = 12;  // max read request size
  localparam int DC_FLR         = 15;  // function-level reset trigger
  localparam int DS_ERR_LSB     = 16;  // four error detected flags
  localparam int DS_TXN_PEND    = 21;  // transaction pending
  localparam int DEV_CAP_RBER   = 15;  // role-based error reporting
  localparam int DEV_CAP_FLR    = 28;  // flr capable
  localparam int LINK_CAP_OPT   = 22;  // aspm optionality compliance

  // ==========================================================================
  // reset values
  localparam logic [2:0] MPS_RST     = 3'h0;  // 128 bytes
  localparam logic [2:0] MRRS_RST    = 3'h2;  // 512 bytes
  localparam logic       NOSNOOP_RST = 1'b1;  // no-snoop on

  // ==========================================================================
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control fields of the device control word
  typedef struct packed {
    logic [3:0] err_en;   // cor, nonfatal, fatal, ur enables
    logic       relax;    // relaxed ordering
    logic [2:0] mps;      // max payload size
    logic       ext_tag;  // extended tag enable
    logic       nosnoop;  // no-snoop enable
    logic [2:0] mrrs;     // max read request size
  } pcr_devctl_t;

endpackage

// ===== design/pcr_regs.sv
// capability structure register bank with axi4-lite slave and event interrupt
// assumes one clock, synchronous active-low reset, error strobes one cycle wide
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module pcr_regs #(
  parameter logic [2:0] MPS_SUPPORTED = 3'h1,  // 000 = 128 b, 001 = 256 b
  parameter logic       EXT_TAG_SUP   = 1'b1,  // extended tags supported
  parameter logic [2:0] L0S_ACC_LAT   = 3'h0,  // acceptable l0s latency
  parameter logic [2:0] L1_ACC_LAT    = 3'h0,  // acceptable l1 latency
  parameter logic       FLR_CAPABLE   = 1'b1,  // function-level reset supported
  parameter logic       RELAX_RST     = 1'b1,  // relaxed ordering reset value
  parameter logic [3:0] LINK_SPEED    = 4'h1,  // maximum link speed code
  parameter logic [5:0] LINK_WIDTH    = 6'h08, // maximum link width
  parameter logic       ASPM_L0S      = 1'b0,  // l0s supported
  parameter logic       ASPM_L1       = 1'b0,  // l1 supported
  parameter logic [2:0] L0S_EXIT_LAT  = 3'h6,  // l0s exit latency
  parameter logic [2:0] L1_EXIT_LAT   = 3'h0   // l1 exit latency
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  // axi4-lite write response
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  // axi4-lite read data
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // error detection strobes from the function: cor, nonfatal, fatal, ur
  input  wire logic [3:0]  err_detect,
  // outstanding non-posted request count above zero
  input  wire logic        np_pending,
  // function-level reset pulse and interrupt
  output var  logic        flr_start,
  output var  logic        irq,
  // programmed control fields to the function
  output var  logic [31:0] dev_control
);

  // ==========================================================================
  // state
  pcr_pkg::pcr_devctl_t ctl;          // device control fields
  logic [3:0]           err_stat;     // error detected flags
  logic                 pend;         // transaction pending
  logic [1:0]           irq_stat;     // bit0 error seen, bit1 pending fell
  logic [1:0]           irq_mask;     // interrupt enables
  logic                 aw_held;      // write address captured
  logic                 w_held;       // write data captured
  logic [11:0]          aw_addr;      // captured write address
  logic [31:0]          w_data;       // captured write data
  logic [3:0]           w_strb;       // captured byte strobes

  // byte-masked write helper
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // address in the implemented window (structure or interrupt words)
  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = (a[1:0] == 2'h0) &&
                  (((a >= pcr_pkg::OFS_HEADER) && (a <= pcr_pkg::OFS_CAP_LAST)) ||
                   (a == pcr_pkg::OFS_IRQ_STAT) || (a == pcr_pkg::OFS_IRQ_MASK));
  endfunction

  // ==========================================================================
  // read-back words; header and both capability words are read-only
  wire logic [31:0] hdr_word = {13'h0000, pcr_pkg::HDR_VERSION,
                                pcr_pkg::HDR_NEXT_PTR, pcr_pkg::HDR_CAP_ID};
  // reserved 31:29, flr 28, slot power 27:18 zero, rber 15
  wire logic [31:0] devcap_word = {3'h0, FLR_CAPABLE, 10'h000, 2'h0, 1'b1, 3'h0,
                                   L1_ACC_LAT, L0S_ACC_LAT, EXT_TAG_SUP, 2'h0,
                                   MPS_SUPPORTED};
  // status half only; the control half comes from devcs_ctl
  wire logic [31:0] devcs_word = {10'h000, pend, 1'b0, err_stat, 16'h0000};
  // control half; flr bit 15 always reads zero
  wire logic [31:0] devcs_ctl = {16'h0000, 1'b0, ctl.mrrs, ctl.nosnoop, 2'h0,
                                 ctl.ext_tag, ctl.mps, ctl.relax, ctl.err_en};
  wire logic [31:0] linkcap_word = {9'h000, 1'b1, 4'h0, L1_EXIT_LAT,
                                    L0S_EXIT_LAT, ASPM_L1, ASPM_L0S,
                                    LINK_WIDTH, LINK_SPEED};

  // ==========================================================================
  // write path decode
  wire logic        wr_go    = aw_held && w_held && !s_axi_bvalid;
  wire logic        wr_ok    = addr_mapped(aw_addr);
  wire logic [31:0] wmask    = strb_mask(w_strb);
  wire logic [31:0] wval     = w_data & wmask;
  wire logic        wr_devcs = wr_go && (aw_addr == pcr_pkg::OFS_DEV_CS);
  wire logic        wr_istat = wr_go && (aw_addr == pcr_pkg::OFS_IRQ_STAT);
  wire logic        wr_imask = wr_go && (aw_addr == pcr_pkg::OFS_IRQ_MASK);
  // merged control word: unwritten bytes keep old value
  wire logic [31:0] ctl_new  = (w_data & wmask) | ((devcs_word | devcs_ctl) & ~wmask);
  wire logic        flr_hit  = wr_devcs && wval[pcr_pkg::DC_FLR] && FLR_CAPABLE;
  wire logic        pend_fell = pend && !np_pending;
  wire logic [1:0]  irq_evt  = {pend_fell, |err_detect};

  // ==========================================================================
  // read path decode
  wire logic        rd_go  = s_axi_arvalid && s_axi_arready;
  wire logic        rd_ok  = addr_mapped(s_axi_araddr);
  logic [31:0]      rd_val;                                            // selected word
  always_comb begin
    unique case (s_axi_araddr)
      pcr_pkg::OFS_HEADER:   rd_val = hdr_word;
      pcr_pkg::OFS_DEV_CAP:  rd_val = devcap_word;
      pcr_pkg::OFS_DEV_CS:   rd_val = devcs_word | devcs_ctl;
      pcr_pkg::OFS_LINK_CAP: rd_val = linkcap_word;
      pcr_pkg::OFS_IRQ_STAT: rd_val = {30'h0, irq_stat};
      pcr_pkg::OFS_IRQ_MASK: rd_val = {30'h0, irq_mask};
      default:               rd_val = 32'h0000_0000;
    endcase
  end

  // ==========================================================================
  // write address / data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // ready while nothing captured
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !wr_go;
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready) && !wr_go;
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pcr_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? pcr_pkg::RESP_OKAY : pcr_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // read channel: one outstanding read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= pcr_pkg::RESP_OKAY;
    end else if (rd_go) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_ok ? pcr_pkg::RESP_OKAY : pcr_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid;
    end
  end

  // ==========================================================================
  // device control fields; only writable bits are taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl.err_en  <= 4'h0;
      ctl.relax   <= RELAX_RST;
      ctl.mps     <= pcr_pkg::MPS_RST;
      ctl.ext_tag <= 1'b0;
      ctl.nosnoop <= pcr_pkg::NOSNOOP_RST;
      ctl.mrrs    <= pcr_pkg::MRRS_RST;
    end else if (wr_devcs) begin
      ctl.err_en  <= ctl_new[pcr_pkg::DC_ERR_EN_LSB +: 4];
      ctl.relax   <= ctl_new[pcr_pkg::DC_RELAX];
      ctl.mps     <= ctl_new[pcr_pkg::DC_MPS_LSB +: 3];
      ctl.ext_tag <= ctl_new[pcr_pkg::DC_EXT_TAG];
      ctl.nosnoop <= ctl_new[pcr_pkg::DC_NOSNOOP];
      ctl.mrrs    <= ctl_new[pcr_pkg::DC_MRRS_LSB +: 3];
    end
  end

  // error detected flags: set wins over write-one-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_stat <= 4'h0;
    end else begin
      err_stat <= (err_stat & ~(wr_devcs ? wval[pcr_pkg::DS_ERR_LSB +: 4] : 4'h0))
                  | err_detect;
    end
  end

  // pending flag and flr pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend      <= 1'b0;
      flr_start <= 1'b0;
    end else begin
      pend      <= np_pending;
      flr_start <= flr_hit;
    end
  end

  // interrupt status, mask and output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= 2'h0;
      irq_mask <= 2'h0;
      irq      <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~(wr_istat ? wval[1:0] : 2'h0)) | irq_evt;
      if (wr_imask) begin
        irq_mask <= wval[1:0];
      end
      irq      <= |(irq_stat & irq_mask);
    end
  end

  // control word to the function
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dev_control <= 32'h0000_0000;
    end else begin
      dev_control <= devcs_ctl;
    end
  end

  // ==========================================================================
  // checks
  property p_flr_pulse;
    @(posedge aclk) disable iff (!aresetn)
      flr_hit |=> flr_start ##1 !flr_start;
  endproperty
  a_flr_pulse: assert property (p_flr_pulse) else $error("flr pulse wrong");

  property p_flr_gate;
    @(posedge aclk) disable iff (!aresetn)
      flr_start |-> $past(wr_devcs) && FLR_CAPABLE;
  endproperty
  a_flr_gate: assert property (p_flr_gate) else $error("flr without write");

  property p_err_sticky;
    @(posedge aclk) disable iff (!aresetn)
      err_detect[0] |=> err_stat[0];
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("error flag lost");

  property p_err_hold;
    @(posedge aclk) disable iff (!aresetn)
      (err_stat[1] && !wr_devcs) |=> err_stat[1];
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag dropped");

  property p_pend;
    @(posedge aclk) disable iff (!aresetn)
      np_pending |=> devcs_word[pcr_pkg::DS_TXN_PEND];
  endproperty
  a_pend: assert property (p_pend) else $error("pending not shown");

  property p_hdr_read;
    @(posedge aclk) disable iff (!aresetn)
      (rd_go && s_axi_araddr == pcr_pkg::OFS_HEADER) |=> s_axi_rdata == 32'h0003_8001;
  endproperty
  a_hdr_read: assert property (p_hdr_read) else $error("header wrong");

  property p_flr_reads0;
    @(posedge aclk) disable iff (!aresetn)
      (rd_go && s_axi_araddr == pcr_pkg::OFS_DEV_CS) |=> !s_axi_rdata[pcr_pkg::DC_FLR];
  endproperty
  a_flr_reads0: assert property (p_flr_reads0) else $error("flr reads one");

  property p_devcap;
    @(posedge aclk) disable iff (!aresetn)
      (rd_go && s_axi_araddr == pcr_pkg::OFS_DEV_CAP) |=>
        s_axi_rdata[pcr_pkg::DEV_CAP_RBER] && (s_axi_rdata[27:16] == 12'h000);
  endproperty
  a_devcap: assert property (p_devcap) else $error("devcap fixed bits wrong");

  property p_linkcap;
    @(posedge aclk) disable iff (!aresetn)
      (rd_go && s_axi_araddr == pcr_pkg::OFS_LINK_CAP) |=>
        s_axi_rdata[pcr_pkg::LINK_CAP_OPT] && (s_axi_rdata[31:23] == 9'h000);
  endproperty
  a_linkcap: assert property (p_linkcap) else $error("linkcap fixed bits wrong");

endmodule

`default_nettype wire

// ===== tb/pcr_host_model.sv
// host-side axi4-lite master issuing configuration accesses
// assumes aclk from the bench; the bench calls wr and rd hierarchically
`timescale 1ns/1ps
`default_nettype none

module pcr_host_model (
  // clock
  input  wire logic        aclk,
  // write channels
  output var  logic [11:0] awaddr,
  output var  logic        awvalid,
  input  wire logic        awready,
  output var  logic [31:0] wdata,
  output var  logic [3:0]  wstrb,
  output var  logic        wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output var  logic        bready,
  // read channels
  output var  logic [11:0] araddr,
  output var  logic        arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output var  logic        rready
);
  // ==========================================================================
  // idle bus at time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // ==========================================================================
  // one write; payload inverted once taken so stale values never look valid
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] resp);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata  <= ~d;
      end
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  // one read; ready held until the answer is sampled
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr  <= ~a;
      end
    end while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
endmodule

`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the capability register bank
// assumes default build parameters of pcr_regs and the host model
`timescale 1ns/1ps
`default_nettype none

module tb;
  // ==========================================================================
  // signals
  logic        aclk = 1'b0;      // 20 mhz clock
  logic        aresetn = 1'b0;   // sync reset
  logic [3:0]  err_detect = '0;  // error strobes
  logic        np_pending = 1'b0;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, dev_control;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, flr_start, irq;
  int          fails = 0;
  int          n_tests = 0;
  int          n_flr = 0;        // flr pulses seen
  int          cyc = 0;          // timeout counter
  localparam logic [1:0] OK = pcr_pkg::RESP_OKAY;
  localparam logic [1:0] SE = pcr_pkg::RESP_SLVERR;

  always #25 aclk = ~aclk;

  // ==========================================================================
  // design and host
  pcr_regs uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .err_detect(err_detect), .np_pending(np_pending),
    .flr_start(flr_start), .irq(irq), .dev_control(dev_control)
  );
  pcr_host_model host (
    .aclk(aclk),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );

  // ==========================================================================
  // watchers: flr pulses and hang limit
  always @(posedge aclk) begin
    if (flr_start === 1'b1)
      n_flr++;
    cyc++;
    if (cyc == 5000) begin
      fails++;
      close_out();
    end
  end

  // ==========================================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
      fails++;
    end
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    host.rd(a, d, r);
    chk({30'h0, r}, {30'h0, OK});
    chk(d, e);
  endtask

  task automatic wrc(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    host.wr(a, d, 4'hf, r);
    chk({30'h0, r}, {30'h0, OK});
  endtask

  task automatic close_out();
    if (fails == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================================
  // ordinary cases: optional write, then read back
  typedef struct packed {
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wd;
    logic [3:0]  st;
    logic [1:0]  wresp;
    logic [1:0]  rresp;
    logic [31:0] rd;
  } pcr_row_t;

  pcr_row_t rows [12] = '{
    '{1'b0, 12'h080, 32'h0, 4'h0, OK, OK, 32'h0003_8001},
    '{1'b0, 12'h084, 32'h0, 4'h0, OK, OK, 32'h1000_8021},
    '{1'b0, 12'h08c, 32'h0, 4'h0, OK, OK, 32'h0040_6081},
    '{1'b0, 12'h088, 32'h0, 4'h0, OK, OK, 32'h0000_2810},
    '{1'b0, 12'h0a4, 32'h0, 4'h0, OK, OK, 32'h0},
    '{1'b0, 12'h0b0, 32'h0, 4'h0, OK, OK, 32'h0},
    '{1'b1, 12'h080, 32'hffff_ffff, 4'hf, OK, OK, 32'h0003_8001},
    '{1'b1, 12'h084, 32'hffff_ffff, 4'hf, OK, OK, 32'h1000_8021},
    '{1'b1, 12'h088, 32'h0000_16ef, 4'hf, OK, OK, 32'h0000_10ef},
    '{1'b1, 12'h088, 32'h0000_ff00, 4'h1, OK, OK, 32'h0000_1000},
    '{1'b1, 12'h100, 32'h0, 4'hf, SE, SE, 32'h0},
    '{1'b0, 12'h082, 32'h0, 4'h0, OK, SE, 32'h0}
  };

  // ==========================================================================
  // main sequence
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(dev_control, 32'h0000_2810);
    chk({31'h0, irq}, 32'h0);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        host.wr(rows[i].addr, rows[i].wd, rows[i].st, r);
        chk({30'h0, r}, {30'h0, rows[i].wresp});
      end
      host.rd(rows[i].addr, d, r);
      chk({30'h0, r}, {30'h0, rows[i].rresp});
      if (rows[i].rresp == OK)
        chk(d, rows[i].rd);
    end
    chk(dev_control, 32'h0000_1000);
    // flr trigger: one pulse, bit reads zero
    wrc(12'h088, 32'h0000_9000);
    repeat (2) @(posedge aclk);
    chk(32'(n_flr), 32'h1);
    rdc(12'h088, 32'h0000_1000);
    // error flags set, then one cleared by writing one
    err_detect <= 4'hf;
    @(posedge aclk);
    err_detect <= 4'h0;
    rdc(12'h088, 32'h000f_1000);
    wrc(12'h088, 32'h0002_1000);
    rdc(12'h088, 32'h000d_1000);
    // pending bit follows the outstanding request
    np_pending <= 1'b1;
    repeat (2) @(posedge aclk);
    rdc(12'h088, 32'h002d_1000);
    np_pending <= 1'b0;
    repeat (2) @(posedge aclk);
    rdc(12'h088, 32'h000d_1000);
    // interrupt: both events pending, masked, unmasked, cleared
    rdc(12'h0c0, 32'h3);
    chk({31'h0, irq}, 32'h0);
    wrc(12'h0c4, 32'h1);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    wrc(12'h0c0, 32'h1);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    rdc(12'h0c4, 32'h1);
    wrc(12'h0c0, 32'h2);
    rdc(12'h0c0, 32'h0);
    // second reset in mid-run restores defaults
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(dev_control, 32'h0000_2810);
    rdc(12'h088, 32'h0000_2810);
    close_out();
  end
endmodule

`default_nettype wire
